//--- core/eccp_cfg.svh
// Register offsets, reset values and timing counts of the enhanced PWM output stage
`ifndef ECCP_CFG_SVH
`define ECCP_CFG_SVH

// ==================================================================
// Byte offsets on the register bus (one aligned word each)
`define OFS_CAPTURE_PWM_CONTROL 6'h00
`define OFS_DUTY_HIGH_BYTE      6'h04
`define OFS_DUTY_SHADOW_BYTE    6'h08
`define OFS_PERIOD_LIMIT        6'h0C
`define OFS_TIMER_CONTROL       6'h10
`define OFS_TIMEBASE_COUNT      6'h14
`define OFS_STEERING_CONTROL    6'h18
`define OFS_DEADBAND_CONTROL    6'h1C
`define OFS_SHUTDOWN_CONTROL    6'h20
`define OFS_PIN_RELOCATION      6'h24
`define OFS_PIN_DIRECTION       6'h28
`define OFS_PIN_STATUS          6'h2C

// ==================================================================
// Reset values
`define RST_BYTE                8'h00
`define RST_PERIOD_LIMIT        8'hFF
`define RST_STEERING            4'h1
`define RST_PIN_DIRECTION       4'hF

// ==================================================================
// Timer control field positions
`define TCON_RUN_BIT            2
`define TCON_PRESCALE_MSB       1

// ==================================================================
// Prescaler limits: one timer step is four clocks times the prescale
`define PRE_LIMIT_DIV1          6'h03
`define PRE_LIMIT_DIV4          6'h0F
`define PRE_LIMIT_DIV16         6'h3F

`endif

//--- core/eccp_pkg.sv
// Types shared by the enhanced PWM output stage
package eccp_pkg;

	// ==================================================================
	// Output arrangement chosen by the bridge output select field
	typedef enum logic [1:0] {
		BRIDGE_SINGLE = 2'b00,
		BRIDGE_FWD    = 2'b01,
		BRIDGE_HALF   = 2'b10,
		BRIDGE_REV    = 2'b11
	} bridge_sel_t;

	// ==================================================================
	// Layout of capture_pwm_control, bit 7 down to bit 0
	typedef struct packed {
		bridge_sel_t bridge_output_select;
		logic [1:0]  duty_low_bits;
		logic [3:0]  module_mode_bits;
	} ctrl_t;

	// ==================================================================
	// Pin drive: level and enable travel together
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] enable;
	} pins_t;

	// ==================================================================
	// Bus answer sequencer
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_t;

endpackage

//--- core/enhanced_pwm_output_steering.sv
// Enhanced PWM output stage: timebase, double-buffered duty and output steering
`timescale 1ns/1ps
`default_nettype none
`include "eccp_cfg.svh"

// Overview of operation
// - Bridge select: 00 single, 10 half-bridge, 01 full forward, 11 full reverse.
// - Half-bridge drives only a and b; both full-bridge modes drive all four.
// - Single mode with steering may enable the waveform on any of a to d.
// - Waveform reaches up to four pins with at most ten bits of duty resolution.
// - Output active levels are chosen by the module mode bits.
// - After enabling, outputs wait for a new period; no partial first pulse.
// - Writing zero to the control register hands the pins back to the port.
// - Pins unused by the chosen arrangement stay free for other functions.
// - Three extra registers hold shutdown, dead-band and steering settings.
// - Pin relocation register bits only appear on pin_relocation_o; the outputs stay on their pins.
// - Unimplemented register bits read back as zero.
// - Bridge select exists here because this is an enhanced unit.
// - At count equal period, next step clears count, sets output unless duty is zero, latches duty.
// - Duty is high byte plus two low bits; output clears on timebase match.
// - Forward: a active, d modulated. Reverse: c active, b modulated.
// - Half-bridge: a carries the waveform, b its complement.
module enhanced_pwm_output_steering
	import eccp_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output var  logic [31:0] avs_readdata_o,
	output var  logic        avs_waitrequest_o,
	output var  logic [3:0]  pwm_out_o,
	output var  logic [3:0]  pwm_oe_o,
	output var  logic [7:0]  pin_relocation_o
);

	// ==================================================================
	// Declarations

	// Bus sequencer
	bus_state_t  bus_ff;
	bus_state_t  nxt_bus;
	logic        wait_ff;
	logic        nxt_wait;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        wr_fire;
	logic [7:0]  wbyte;

	// Software registers
	ctrl_t       ctrl_ff;
	ctrl_t       nxt_ctrl;
	logic [7:0]  duty_hi_ff;
	logic [7:0]  nxt_duty_hi;
	logic [7:0]  period_ff;
	logic [7:0]  nxt_period;
	logic [2:0]  tcon_ff;
	logic [2:0]  nxt_tcon;
	logic [3:0]  steer_ff;
	logic [3:0]  nxt_steer;
	logic [6:0]  dband_ff;
	logic [6:0]  nxt_dband;
	logic [7:0]  shut_ff;
	logic [7:0]  nxt_shut;
	logic [7:0]  reloc_ff;
	logic [7:0]  nxt_reloc;
	logic [3:0]  dir_ff;
	logic [3:0]  nxt_dir;

	// Timebase and duty buffer
	logic [5:0]  pre_ff;
	logic [5:0]  nxt_pre;
	logic [7:0]  tmr_ff;
	logic [7:0]  nxt_tmr;
	logic [9:0]  shadow_ff;
	logic [9:0]  nxt_shadow;
	logic        mod_ff;
	logic        nxt_mod;
	logic        armed_ff;
	logic        nxt_armed;
	logic [5:0]  pre_lim;
	logic [1:0]  fine;
	logic        run;
	logic        tick;
	logic        rollover;
	logic [9:0]  duty_req;
	logic        mod_on;

	// Pin stage
	logic        pwm_mode;
	logic [3:0]  used;
	logic [3:0]  level;
	logic [3:0]  inv;
	pins_t       pins_ff;
	pins_t       nxt_pins;

	// ==================================================================
	// Bus answer: one wait cycle, then the request completes

	// A write lands only on the edge where waitrequest is seen low
	assign wr_fire = avs_write_i && (bus_ff == BUS_ACK) && avs_byteenable_i[0];
	assign wbyte   = avs_writedata_i[7:0];

	// Read data is captured on entry to the answer cycle so it is stable there
	always_comb begin
		nxt_bus   = bus_ff;
		nxt_rdata = rdata_ff;
		case (bus_ff)
			BUS_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					nxt_bus = BUS_ACK;
				end
				if (avs_read_i) begin
					nxt_rdata = 32'h0000_0000;
					if (avs_address_i == `OFS_CAPTURE_PWM_CONTROL) begin
						nxt_rdata[7:0] = ctrl_ff;
					end else if (avs_address_i == `OFS_DUTY_HIGH_BYTE) begin
						nxt_rdata[7:0] = duty_hi_ff;
					end else if (avs_address_i == `OFS_DUTY_SHADOW_BYTE) begin
						nxt_rdata[7:0] = shadow_ff[9:2];
					end else if (avs_address_i == `OFS_PERIOD_LIMIT) begin
						nxt_rdata[7:0] = period_ff;
					end else if (avs_address_i == `OFS_TIMER_CONTROL) begin
						nxt_rdata[2:0] = tcon_ff;
					end else if (avs_address_i == `OFS_TIMEBASE_COUNT) begin
						nxt_rdata[7:0] = tmr_ff;
					end else if (avs_address_i == `OFS_STEERING_CONTROL) begin
						nxt_rdata[3:0] = steer_ff;
					end else if (avs_address_i == `OFS_DEADBAND_CONTROL) begin
						nxt_rdata[6:0] = dband_ff;
					end else if (avs_address_i == `OFS_SHUTDOWN_CONTROL) begin
						nxt_rdata[7:0] = shut_ff;
					end else if (avs_address_i == `OFS_PIN_RELOCATION) begin
						nxt_rdata[7:0] = reloc_ff;
					end else if (avs_address_i == `OFS_PIN_DIRECTION) begin
						nxt_rdata[3:0] = dir_ff;
					end else if (avs_address_i == `OFS_PIN_STATUS) begin
						nxt_rdata[7:0] = {pins_ff.enable, pins_ff.level};
					end
				end
			end
			BUS_ACK: begin
				nxt_bus = BUS_IDLE;
			end
			default: begin
				nxt_bus = BUS_IDLE;
			end
		endcase
		nxt_wait = (nxt_bus != BUS_ACK);
	end

	// Bus registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bus_ff   <= BUS_IDLE;
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			bus_ff   <= nxt_bus;
			wait_ff  <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	assign avs_waitrequest_o = wait_ff;
	assign avs_readdata_o    = rdata_ff;

	// ==================================================================
	// Software registers

	// Only byte lane 0 carries data; other lanes are ignored
	always_comb begin
		nxt_ctrl    = ctrl_ff;
		nxt_duty_hi = duty_hi_ff;
		nxt_period  = period_ff;
		nxt_tcon    = tcon_ff;
		nxt_steer   = steer_ff;
		nxt_dband   = dband_ff;
		nxt_shut    = shut_ff;
		nxt_reloc   = reloc_ff;
		nxt_dir     = dir_ff;
		if (wr_fire) begin
			if (avs_address_i == `OFS_CAPTURE_PWM_CONTROL) begin
				nxt_ctrl = ctrl_t'(wbyte);
			end else if (avs_address_i == `OFS_DUTY_HIGH_BYTE) begin
				nxt_duty_hi = wbyte;
			end else if (avs_address_i == `OFS_PERIOD_LIMIT) begin
				nxt_period = wbyte;
			end else if (avs_address_i == `OFS_TIMER_CONTROL) begin
				nxt_tcon = wbyte[2:0];
			end else if (avs_address_i == `OFS_STEERING_CONTROL) begin
				nxt_steer = wbyte[3:0];
			end else if (avs_address_i == `OFS_DEADBAND_CONTROL) begin
				nxt_dband = wbyte[6:0];
			end else if (avs_address_i == `OFS_SHUTDOWN_CONTROL) begin
				nxt_shut = wbyte;
			end else if (avs_address_i == `OFS_PIN_RELOCATION) begin
				nxt_reloc = wbyte;
			end else if (avs_address_i == `OFS_PIN_DIRECTION) begin
				nxt_dir = wbyte[3:0];
			end
		end
	end

	// Register file storage
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_ff    <= ctrl_t'(`RST_BYTE);
			duty_hi_ff <= `RST_BYTE;
			period_ff  <= `RST_PERIOD_LIMIT;
			tcon_ff    <= 3'h0;
			steer_ff   <= `RST_STEERING;
			dband_ff   <= 7'h00;
			shut_ff    <= `RST_BYTE;
			reloc_ff   <= `RST_BYTE;
			dir_ff     <= `RST_PIN_DIRECTION;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			duty_hi_ff <= nxt_duty_hi;
			period_ff  <= nxt_period;
			tcon_ff    <= nxt_tcon;
			steer_ff   <= nxt_steer;
			dband_ff   <= nxt_dband;
			shut_ff    <= nxt_shut;
			reloc_ff   <= nxt_reloc;
			dir_ff     <= nxt_dir;
		end
	end

	assign pin_relocation_o = reloc_ff;

	// ==================================================================
	// Timebase: 8-bit count plus two fine bits form the 10-bit timebase

	assign pwm_mode = (ctrl_ff.module_mode_bits[3:2] == 2'b11);
	assign run      = tcon_ff[`TCON_RUN_BIT];
	assign duty_req = {duty_hi_ff, ctrl_ff.duty_low_bits};

	// Fine bits come from the prescaler's top two bits of the active range
	always_comb begin
		case (tcon_ff[`TCON_PRESCALE_MSB:0])
			2'b00: begin
				pre_lim = `PRE_LIMIT_DIV1;
				fine    = pre_ff[1:0];
			end
			2'b01: begin
				pre_lim = `PRE_LIMIT_DIV4;
				fine    = pre_ff[3:2];
			end
			default: begin
				pre_lim = `PRE_LIMIT_DIV16;
				fine    = pre_ff[5:4];
			end
		endcase
	end

	assign tick     = run && (pre_ff == pre_lim);
	assign rollover = tick && (tmr_ff == period_ff);

	// Rollover beats the duty match, so a duty past the period keeps the pin set
	always_comb begin
		nxt_pre    = pre_ff;
		nxt_tmr    = tmr_ff;
		nxt_shadow = shadow_ff;
		nxt_mod    = mod_ff;
		nxt_armed  = armed_ff;
		if (tick) begin
			nxt_pre = 6'h00;
			if (rollover) begin
				nxt_tmr = 8'h00;
			end else begin
				nxt_tmr = tmr_ff + 8'h01;
			end
		end else if (run) begin
			nxt_pre = pre_ff + 6'h01;
		end
		if (rollover) begin
			nxt_shadow = duty_req;
			nxt_mod    = (duty_req != 10'h000);
			nxt_armed  = pwm_mode;
		end else if ({tmr_ff, fine} == shadow_ff) begin
			nxt_mod = 1'b0;
		end
		// Leaving PWM mode disarms, so re-entry waits for a full period
		if (!pwm_mode) begin
			nxt_armed = 1'b0;
			nxt_mod   = 1'b0;
		end
		// A software write to the count restarts the prescaler too
		if (wr_fire && (avs_address_i == `OFS_TIMEBASE_COUNT)) begin
			nxt_tmr = wbyte;
			nxt_pre = 6'h00;
		end
	end

	// Timebase registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pre_ff    <= 6'h00;
			tmr_ff    <= 8'h00;
			shadow_ff <= 10'h000;
			mod_ff    <= 1'b0;
			armed_ff  <= 1'b0;
		end else begin
			pre_ff    <= nxt_pre;
			tmr_ff    <= nxt_tmr;
			shadow_ff <= nxt_shadow;
			mod_ff    <= nxt_mod;
			armed_ff  <= nxt_armed;
		end
	end

	// The clear is registered, so the match cycle itself must already read inactive
	assign mod_on = mod_ff && ({tmr_ff, fine} != shadow_ff);

	// ==================================================================
	// Output steering; vectors are ordered d, c, b, a from bit 3 down

	// Logical levels per arrangement; all inactive until armed
	always_comb begin
		case (ctrl_ff.bridge_output_select)
			BRIDGE_SINGLE: begin
				used  = steer_ff;
				level = {4{mod_on}};
			end
			BRIDGE_HALF: begin
				used  = 4'h3;
				level = {2'b00, ~mod_on, mod_on};
			end
			BRIDGE_FWD: begin
				used  = 4'hF;
				level = {mod_on, 1'b0, 1'b0, 1'b1};
			end
			BRIDGE_REV: begin
				used  = 4'hF;
				level = {1'b0, 1'b1, mod_on, 1'b0};
			end
			default: begin
				used  = 4'h1;
				level = 4'h0;
			end
		endcase
		if (!armed_ff) begin
			level = 4'h0;
		end
	end

	// Mode bit 1 inverts a and c, mode bit 0 inverts b and d
	assign inv = {ctrl_ff.module_mode_bits[0], ctrl_ff.module_mode_bits[1],
		ctrl_ff.module_mode_bits[0], ctrl_ff.module_mode_bits[1]};

	// Per pin: drive only when in PWM mode, used, and direction bit clear
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
			assign nxt_pins.enable[gi] = pwm_mode && used[gi] && !dir_ff[gi];
			assign nxt_pins.level[gi]  = nxt_pins.enable[gi] && (level[gi] ^ inv[gi]);
		end
	endgenerate

	// Pins are registered so the outputs never glitch on decode changes
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pins_ff <= '0;
		end else begin
			pins_ff <= nxt_pins;
		end
	end

	assign pwm_out_o = pins_ff.level;
	assign pwm_oe_o  = pins_ff.enable;

endmodule
`default_nettype wire

//--- verification/pwm_steer_asserts.sv
// Port-level assertions for the enhanced PWM output stage
`timescale 1ns/1ps
`default_nettype none
`include "eccp_cfg.svh"
module pwm_steer_asserts
	import eccp_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic [5:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic [3:0]  pwm_out_o,
	input wire logic [3:0]  pwm_oe_o,
	input wire logic [7:0]  pin_relocation_o
);
	// ==================================================================
	// Copy of the control byte; pins are judged only once it has settled
	ctrl_t      ctrl_ff;
	ctrl_t      nxt_ctrl;
	logic [1:0] settle_ff;
	logic [1:0] nxt_settle;
	logic       done;
	logic       calm;
	logic [7:0] wbyte;
	assign wbyte = avs_writedata_i[7:0];
	assign done  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign calm  = settle_ff == 2'h3 && ctrl_ff.module_mode_bits == 4'hC;
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_settle = (settle_ff == 2'h3) ? settle_ff : settle_ff + 2'h1;
		if (done && avs_address_i == `OFS_CAPTURE_PWM_CONTROL) begin
			nxt_ctrl   = ctrl_t'(wbyte);
			nxt_settle = 2'h0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_ff   <= '0;
			settle_ff <= 2'h0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			settle_ff <= nxt_settle;
		end
	end
	// ==================================================================
	// Bus handshake and pin relations
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	ack_next_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("request not answered after one wait");
	idle_high_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
		else $error("answer without request");
	reset_quiet_a: assert property (disable iff (1'b0) !rst_n_i |=> avs_waitrequest_o
		&& pwm_oe_o == 4'h0 && pin_relocation_o == 8'h00) else $error("reset state wrong");
	reloc_follow_a: assert property (done && avs_address_i == `OFS_PIN_RELOCATION
		|=> ##[0:1] pin_relocation_o == $past(wbyte, 2)) else $error("relocation lost");
	release_a: assert property (settle_ff == 2'h3 && ctrl_ff == '0 |-> pwm_oe_o == 4'h0)
		else $error("pins kept after control cleared");
	half_unused_a: assert property (calm && ctrl_ff.bridge_output_select == BRIDGE_HALF
		|-> pwm_oe_o[3:2] == 2'b00) else $error("half-bridge drives c or d");
	half_compl_a: assert property (calm && ctrl_ff.bridge_output_select == BRIDGE_HALF
		&& $rose(pwm_out_o[0]) |-> !pwm_out_o[1]) else $error("b not complement of a");
	fwd_drive_a: assert property (calm && ctrl_ff.bridge_output_select == BRIDGE_FWD
		&& $rose(pwm_out_o[3]) |-> pwm_out_o[2:0] == 3'b001) else $error("forward levels");
	rev_drive_a: assert property (calm && ctrl_ff.bridge_output_select == BRIDGE_REV
		&& $rose(pwm_out_o[1]) |-> pwm_out_o[3:2] == 2'b01 && !pwm_out_o[0])
		else $error("reverse levels");
	half_c: cover property (calm && ctrl_ff.bridge_output_select == BRIDGE_HALF && $rose(pwm_out_o[0]));
	fwd_c: cover property (calm && ctrl_ff.bridge_output_select == BRIDGE_FWD && $rose(pwm_out_o[3]));
	rev_c: cover property (calm && ctrl_ff.bridge_output_select == BRIDGE_REV && $rose(pwm_out_o[1]));
endmodule
bind enhanced_pwm_output_steering pwm_steer_asserts chk_u (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o),
	.pin_relocation_o(pin_relocation_o));
`default_nettype wire

//--- verification/bridge_driver_model.sv
// Power-switch driver inputs seen behind the PWM pins
`timescale 1ns/1ps
`default_nettype none
module bridge_driver_model
	import eccp_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire pins_t pins_i,
	output var  logic [3:0] gate_o
);
	// ==================================================================
	// A released pin floats: show the inverse so a stale level never passes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			gate_o <= 4'h0;
		end else begin
			gate_o <= (pins_i.enable & pins_i.level) | (~pins_i.enable & ~gate_o);
		end
	end
endmodule
`default_nettype wire

//--- verification/tb_enhanced_pwm_output_steering.sv
// Self-checking bench for the enhanced PWM output stage
`timescale 1ns/1ps
`default_nettype none
`include "eccp_cfg.svh"
module tb_enhanced_pwm_output_steering
	import eccp_pkg::*;
;
	// ==================================================================
	// Period 3 at prescale 1 is 16 clocks; duty 6 gives HI cycles per 64
	localparam int PER = 16;
	localparam int HI  = 6 * 64 / PER;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [31:0] rdata;
	logic        wait_o;
	logic [3:0]  out;
	logic [3:0]  oe;
	logic [3:0]  gate;
	logic [7:0]  reloc;
	pins_t       pins;
	int          n_mismatch = 0;
	int          checked = 0;
	assign pins = '{level: out, enable: oe};
	always #5 clk = ~clk;
	enhanced_pwm_output_steering dut_u (.core_clk_i(clk), .rst_n_i(rst_n),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
		.pwm_out_o(out), .pwm_oe_o(oe), .pin_relocation_o(reloc));
	bridge_driver_model drv_u (.clk_i(clk), .rst_n_i(rst_n), .pins_i(pins), .gate_o(gate));
	// ==================================================================
	// Compare and bus tasks; the request holds until waitrequest is seen low
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h000000, d};
		@(posedge clk iff wait_o === 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic put(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic peek(input string what, input logic [5:0] a, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(what, {24'h000000, exp}, q);
	endtask
	// Select a mode, let it settle, then count high cycles behind each pin
	task automatic run_mode(input logic [7:0] ctl, input logic [3:0] steer,
		input logic [3:0] eoe, input int ea, input int eb, input int ec, input int ed);
		logic [31:0] c[4];
		logic [31:0] e[4];
		e = '{ea, eb, ec, ed};
		c = '{32'h0, 32'h0, 32'h0, 32'h0};
		put(`OFS_STEERING_CONTROL, {4'h0, steer});
		put(`OFS_CAPTURE_PWM_CONTROL, ctl);
		repeat (3 * PER) @(posedge clk);
		chk("pin enables", {28'h0, eoe}, {28'h0, oe});
		repeat (64) begin
			@(posedge clk);
			for (int j = 0; j < 4; j++) c[j] += gate[j];
		end
		for (int j = 0; j < 4; j++) if (eoe[j]) chk("pin high cycles", e[j], c[j]);
	endtask
	// ==================================================================
	// Scenarios
	task automatic t_reset;
		peek("period", `OFS_PERIOD_LIMIT, 8'hFF);
		peek("steering", `OFS_STEERING_CONTROL, 8'h01);
		peek("direction", `OFS_PIN_DIRECTION, 8'h0F);
		peek("unmapped word", 6'h3C, 8'h00);
		put(`OFS_DEADBAND_CONTROL, 8'hFF);
		peek("deadband", `OFS_DEADBAND_CONTROL, 8'h7F);
		chk("relocation pins", 32'h0, {24'h0, reloc});
	endtask
	task automatic t_reloc;
		be <= 4'hE;
		put(`OFS_PIN_RELOCATION, 8'h5A);
		be <= 4'hF;
		peek("relocation lane off", `OFS_PIN_RELOCATION, 8'h00);
		put(`OFS_PIN_RELOCATION, 8'hA5);
		@(posedge clk);
		chk("relocation pins", 32'hA5, {24'h0, reloc});
		peek("relocation", `OFS_PIN_RELOCATION, 8'hA5);
	endtask
	task automatic t_modes;
		put(`OFS_PERIOD_LIMIT, 8'h03);
		put(`OFS_DUTY_HIGH_BYTE, 8'h01);
		put(`OFS_TIMER_CONTROL, 8'h04);
		put(`OFS_PIN_DIRECTION, 8'h01);
		run_mode({BRIDGE_SINGLE, 6'h2C}, 4'h1, 4'h0, 0, 0, 0, 0);
		put(`OFS_PIN_DIRECTION, 8'h00);
		run_mode({BRIDGE_SINGLE, 6'h2C}, 4'h1, 4'h1, HI, 0, 0, 0);
		run_mode({BRIDGE_SINGLE, 6'h2E}, 4'h1, 4'h1, 64 - HI, 0, 0, 0);
		run_mode({BRIDGE_HALF, 6'h2C}, 4'h1, 4'h3, HI, 64 - HI, 0, 0);
		run_mode({BRIDGE_FWD, 6'h2C}, 4'h1, 4'hF, 64, 0, 0, HI);
		run_mode({BRIDGE_REV, 6'h2C}, 4'h1, 4'hF, 0, HI, 64, 0);
		run_mode({BRIDGE_SINGLE, 6'h2C}, 4'hF, 4'hF, HI, HI, HI, HI);
	endtask
	// Prescale 4 stretches every timebase step to four times as many clocks
	task automatic t_prescale;
		logic [31:0] c;
		c = 32'h0;
		put(`OFS_TIMER_CONTROL, 8'h05);
		repeat (12 * PER) @(posedge clk);
		repeat (16 * PER) begin
			@(posedge clk);
			c += gate[0];
		end
		chk("prescale 4 high cycles", 4 * HI, c);
		put(`OFS_TIMER_CONTROL, 8'h04);
		// A count write also clears a prescaler left beyond the shorter limit
		put(`OFS_TIMEBASE_COUNT, 8'h00);
	endtask
	// A stopped timer never rolls over, so the shadow must keep its old duty
	task automatic t_buffer;
		put(`OFS_DUTY_SHADOW_BYTE, 8'hFF);
		peek("duty shadow", `OFS_DUTY_SHADOW_BYTE, 8'h01);
		put(`OFS_TIMER_CONTROL, 8'h00);
		put(`OFS_DUTY_HIGH_BYTE, 8'h02);
		repeat (2 * PER) @(posedge clk);
		peek("duty shadow held", `OFS_DUTY_SHADOW_BYTE, 8'h01);
		put(`OFS_TIMER_CONTROL, 8'h04);
		repeat (2 * PER) @(posedge clk);
		peek("duty shadow", `OFS_DUTY_SHADOW_BYTE, 8'h02);
		put(`OFS_CAPTURE_PWM_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		chk("pin enables", 32'h0, {28'h0, oe});
		peek("pin status", `OFS_PIN_STATUS, 8'h00);
	endtask
	// ==================================================================
	// Verdict, main sequence and watchdog
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_reloc;
		t_modes;
		t_prescale;
		t_buffer;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		complete_run;
	end
endmodule
`default_nettype wire
